// [design/vts_angle_hist.sv]
// Angle history of one channel and shift detection over the window
`timescale 1ns/1ns
module vts_angle_hist
   import vts_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Measurement
   input wire logic upd,
   input wire logic [ANG_W-1:0] ang,
   input wire logic [ALIM_W-1:0] lim,
   // Result
   output logic shift_small
);
   logic [ANG_W-1:0] hist [HIST_DEPTH];
   logic [ANG_W-1:0] raw;
   logic [ANG_W-1:0] diff;

   // Shift register of past angles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < HIST_DEPTH; i++) begin
            hist[i] <= '0;
         end
      end else if (upd) begin
         hist[0] <= ang;
         for (int i = 1; i < HIST_DEPTH; i++) begin
            hist[i] <= hist[i-1];
         end
      end
   end

   // Shortest angular distance
   always_comb begin
      raw = (ang >= hist[HIST_DEPTH-1]) ? ang - hist[HIST_DEPTH-1] : hist[HIST_DEPTH-1] - ang;
      diff = (raw > ANG_HALF) ? ANG_FULL - raw : raw;
   end

   assign shift_small = diff < {{(ANG_W-ALIM_W){1'b0}}, lim};
endmodule : vts_angle_hist

// [design/vts_core.sv]
// Voltage transformer supervision core with APB register slave
`timescale 1ns/1ns
// Operation
// - Inputs are four fundamental magnitudes refreshed every 5 ms update.
// - Positive, negative and zero sequence voltages computed and used.
// - Phase angle of every channel is tracked alongside magnitudes.
// - Node mode On, Blocked, Test, Test/Blocked, Off; default On; gated globally.
// - With global forcing enabled, status forced to a chosen condition.
// - Pick-up when one phase below low limit and two above high.
// - Low limit 0.05 to 0.50, high 0.01 to 1.10, 0.01 steps.
// - Each phase's magnitude continuously compared with both set limits.
// - Angle change over 40 ms below shift limit blocks pick-up.
// - Bus fuse trip supervised only when bus check enabled.
// - Line fuse trip supervised only when line check enabled.
// - Setting group selection changes limits while running.
// - Mode and forcing settings do not depend on setting group.
// - Bus dead with no voltage; bus live healthy when within limits.
// - Reversed sequence reported when within limits but order reversed.
// - Undefined sequence reported when order cannot be determined.
// - Bus live problem reported whenever pick-up conditions hold, unless all four channels are below low limit (bus dead).
// - Pick-up gives start unless blocked; blocking resets active start.
// - Alarm timed by definite time delay from pick-up.
module vts_core
   import vts_pkg::*;
(
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Measurements
   input wire logic meas_valid,
   input wire logic [MAG_W-1:0] mag0,
   input wire logic [MAG_W-1:0] mag1,
   input wire logic [MAG_W-1:0] mag2,
   input wire logic [MAG_W-1:0] mag3,
   input wire logic [ANG_W-1:0] ang0,
   input wire logic [ANG_W-1:0] ang1,
   input wire logic [ANG_W-1:0] ang2,
   input wire logic [ANG_W-1:0] ang3,
   // System inputs
   input wire logic block_in,
   input wire logic setting_group,
   input wire logic individual_mode_allow,
   input wire logic stage_forcing_enable,
   input wire logic bus_miniature_breaker_trip,
   input wire logic line_miniature_breaker_trip,
   // Outputs
   output logic start,
   output logic blocked,
   output logic alarm,
   output logic bus_transformer_failure,
   output logic line_transformer_failure,
   output logic [2:0] condition,
   output logic [2:0] bus_state
);
   logic [31:0] ctrl, next_rdata;
   logic [25:0] grp [2];
   logic [15:0] delay_set, delay_cnt;
   logic [MAG_W-1:0] seq_pos, seq_neg, seq_zero, next_pos, next_neg, next_zero;
   logic [3:0] below_low, above_high, shift_small;
   logic [MAG_W-1:0] mags [4];
   logic [ANG_W-1:0] angs [4];
   logic [LIM_W-1:0] low_lim, high_lim;
   logic [ALIM_W-1:0] ang_lim;
   logic low_any, high_two, angle_block, pickup, all_low, seq_fwd, seq_rev;
   logic [ANG_W-1:0] d12, d23;
   logic [MAG_W+1:0] mag_sum;
   logic [MAG_W-1:0] mag_max, mag_min, avg;
   vts_mode_e mode;
   logic mode_run, mode_blk, bus_chk, line_chk, bus_fuse_fail, line_fuse_fail;
   logic [2:0] next_cond, next_bus;
   logic wr_en, addr_ok;

   assign mags = '{mag0, mag1, mag2, mag3};
   assign angs = '{ang0, ang1, ang2, ang3};

   // Active group limits
   assign low_lim = grp[setting_group][LIM_W-1:0];
   assign high_lim = grp[setting_group][GRP_HIGH_LSB +: LIM_W];
   assign ang_lim = grp[setting_group][GRP_ANG_LSB +: ALIM_W];

   // Mode and forcing live outside the groups
   assign mode = individual_mode_allow ? vts_mode_e'(ctrl[CTRL_MODE_LSB +: 3]) : MODE_ON;
   assign mode_run = (mode != MODE_OFF);
   assign mode_blk = (mode == MODE_BLOCKED) || (mode == MODE_TEST_BLOCKED);
   assign bus_chk = ctrl[CTRL_BUSCHK_BIT];
   assign line_chk = ctrl[CTRL_LINECHK_BIT];

   // Per channel comparison and angle history
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_ch
         vts_phase_cmp u_cmp (.mag(mags[g]), .low_lim(low_lim), .high_lim(high_lim),
            .below_low(below_low[g]), .above_high(above_high[g]));
         vts_angle_hist u_ang (.pclk(pclk), .presetn(presetn), .upd(meas_valid),
            .ang(angs[g]), .lim(ang_lim),
            .shift_small(shift_small[g]));
      end
   endgenerate

   // Pick-up decision
   assign low_any = |below_low[2:0];
   assign high_two = (above_high[0] & above_high[1]) | (above_high[0] & above_high[2])
                   | (above_high[1] & above_high[2]);
   assign angle_block = &shift_small;
   assign pickup = low_any && high_two && !angle_block;
   assign all_low = &below_low;

   // Phase order from angle spacing
   always_comb begin
      d12 = (ang0 >= ang1) ? ang0 - ang1 : ANG_FULL - (ang1 - ang0);
      d23 = (ang1 >= ang2) ? ang1 - ang2 : ANG_FULL - (ang2 - ang1);
      seq_fwd = (d12 > ANG_THIRD - SEQ_TOL) && (d12 < ANG_THIRD + SEQ_TOL)
             && (d23 > ANG_THIRD - SEQ_TOL) && (d23 < ANG_THIRD + SEQ_TOL);
      seq_rev = (d12 > ANG_TWO_THIRD - SEQ_TOL) && (d12 < ANG_TWO_THIRD + SEQ_TOL)
             && (d23 > ANG_TWO_THIRD - SEQ_TOL) && (d23 < ANG_TWO_THIRD + SEQ_TOL);
   end

   // Sequence voltage estimates
   always_comb begin
      mag_sum = {2'b00, mag0} + {2'b00, mag1} + {2'b00, mag2};
      avg = MAG_W'((34'(mag_sum) * 34'd21846) >> 16);
      mag_max = (mag0 > mag1) ? mag0 : mag1;
      mag_max = (mag2 > mag_max) ? mag2 : mag_max;
      mag_min = (mag0 < mag1) ? mag0 : mag1;
      mag_min = (mag2 < mag_min) ? mag2 : mag_min;
      next_pos = seq_fwd ? avg : '0;
      next_neg = seq_rev ? avg : '0;
      next_zero = mag_max - mag_min;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_pos <= '0;
         seq_neg <= '0;
         seq_zero <= '0;
      end else if (meas_valid) begin
         seq_pos <= next_pos;
         seq_neg <= next_neg;
         seq_zero <= next_zero;
      end
   end

   // Bus voltage state
   always_comb begin
      if (all_low) begin
         next_bus = BUS_DEAD;
      end else if (pickup) begin
         next_bus = BUS_LIVE_PROBLEM;
      end else if (next_zero > {{(MAG_W-LIM_W){1'b0}}, low_lim}) begin
         next_bus = BUS_LIVE_UNDEF;
      end else if (next_pos != '0) begin
         next_bus = BUS_LIVE_OK;
      end else if (next_neg != '0) begin
         next_bus = BUS_LIVE_REV;
      end else begin
         next_bus = BUS_LIVE_UNDEF;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_state <= BUS_DEAD;
      end else if (meas_valid) begin
         bus_state <= next_bus;
      end
   end

   // Start and blocked
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start <= 1'b0;
         blocked <= 1'b0;
      end else if (meas_valid) begin
         start <= mode_run && pickup && !block_in && !mode_blk;
         blocked <= mode_run && pickup && (block_in || mode_blk);
      end
   end

   // Fuse supervision
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_fuse_fail <= 1'b0;
         line_fuse_fail <= 1'b0;
      end else if (meas_valid) begin
         bus_fuse_fail <= mode_run && bus_chk && bus_miniature_breaker_trip;
         line_fuse_fail <= mode_run && line_chk && line_miniature_breaker_trip;
      end
   end

   // Definite time delay from pick-up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         delay_cnt <= '0;
         alarm <= 1'b0;
      end else if (meas_valid) begin
         if (mode_run && pickup && !block_in && !mode_blk) begin
            if (delay_cnt < delay_set) begin
               delay_cnt <= delay_cnt + 16'h0001;
            end
            alarm <= (delay_cnt + 16'h0001 >= delay_set);
         end else begin
            delay_cnt <= '0;
            alarm <= 1'b0;
         end
      end
   end

   assign bus_transformer_failure = alarm || bus_fuse_fail;
   assign line_transformer_failure = line_fuse_fail;

   // Function condition with forcing
   always_comb begin
      if (stage_forcing_enable) begin
         next_cond = ctrl[CTRL_FORCE_LSB +: 3];
      end else if (blocked) begin
         next_cond = COND_BLOCKED;
      end else if (bus_transformer_failure) begin
         next_cond = COND_BUS_FAIL;
      end else if (line_fuse_fail) begin
         next_cond = COND_LINE_FAIL;
      end else if (start) begin
         next_cond = COND_START;
      end else begin
         next_cond = COND_NORMAL;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         condition <= COND_NORMAL;
      end else begin
         condition <= next_cond;
      end
   end

   // APB slave, zero wait states
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_GRP0) || (paddr == ADDR_GRP1)
                 || (paddr == ADDR_STATUS) || (paddr == ADDR_SEQ) || (paddr == ADDR_ZERO)
                 || (paddr == ADDR_DELAY);
   assign pslverr = psel && penable && !addr_ok;

   function automatic logic [25:0] clamp_grp(input logic [31:0] d);
      logic [LIM_W-1:0] lo;
      logic [LIM_W-1:0] hi;
      logic [ALIM_W-1:0] an;
      lo = d[LIM_W-1:0];
      hi = d[GRP_HIGH_LSB +: LIM_W];
      an = d[GRP_ANG_LSB +: ALIM_W];
      lo = (lo < LOW_MIN) ? LOW_MIN : (lo > LOW_MAX) ? LOW_MAX : lo;
      hi = (hi < HIGH_MIN) ? HIGH_MIN : (hi > HIGH_MAX) ? HIGH_MAX : hi;
      an = (an < ALIM_MIN) ? ALIM_MIN : (an > ALIM_MAX) ? ALIM_MAX : an;
      return {an, hi, lo};
   endfunction : clamp_grp

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RST;
         grp[0] <= {ALIM_DEF, HIGH_DEF, LOW_DEF};
         grp[1] <= {ALIM_DEF, HIGH_DEF, LOW_DEF};
         delay_set <= DELAY_DEF;
      end else if (wr_en) begin
         case (paddr)
            ADDR_CTRL: begin
               ctrl <= {22'h0, pwdata[9:8], 1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
            end
            ADDR_GRP0: grp[0] <= clamp_grp(pwdata);
            ADDR_GRP1: grp[1] <= clamp_grp(pwdata);
            ADDR_DELAY: delay_set <= (pwdata[15:0] == '0) ? 16'h0001 : pwdata[15:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      case (paddr)
         ADDR_CTRL: next_rdata = ctrl;
         ADDR_GRP0: next_rdata = {6'h00, grp[0]};
         ADDR_GRP1: next_rdata = {6'h00, grp[1]};
         ADDR_STATUS: next_rdata = {12'h000, below_low, above_high, 1'b0, alarm, blocked,
                                    start, 1'b0, bus_state, 1'b0, condition};
         ADDR_SEQ: next_rdata = {seq_neg, seq_pos};
         ADDR_ZERO: next_rdata = {16'h0000, seq_zero};
         ADDR_DELAY: next_rdata = {16'h0000, delay_set};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel && !penable) begin
         prdata <= next_rdata;
      end
   end

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_excl;
      !(start && blocked);
   endproperty
   a_excl: assert property (p_excl) else $error("start and blocked together");
   property p_start;
      meas_valid && pickup && !block_in && mode == MODE_ON |=> start && !blocked;
   endproperty
   a_start: assert property (p_start) else $error("start missing");
   property p_block;
      meas_valid && pickup && block_in && mode_run |=> blocked ##0 !start;
   endproperty
   a_block: assert property (p_block) else $error("blocked missing");
   property p_hold;
      !meas_valid |=> $stable(bus_state) && $stable(start);
   endproperty
   a_hold: assert property (p_hold) else $error("status moved between updates");
   property p_bus_chk;
      meas_valid && !bus_chk |=> !bus_fuse_fail;
   endproperty
   a_bus_chk: assert property (p_bus_chk) else $error("bus fuse flagged unchecked");
   property p_line_chk;
      meas_valid && line_chk && line_miniature_breaker_trip && mode_run
         |=> line_transformer_failure;
   endproperty
   a_line_chk: assert property (p_line_chk) else $error("line fuse missed");
   property p_pickup;
      pickup |-> (mag0 < MAG_W'(low_lim) || mag1 < MAG_W'(low_lim) || mag2 < MAG_W'(low_lim))
         && high_two && !(&shift_small);
   endproperty
   a_pickup: assert property (p_pickup) else $error("pick-up without cause");
   property p_dead;
      meas_valid && all_low |=> bus_state == BUS_DEAD;
   endproperty
   a_dead: assert property (p_dead) else $error("bus dead not shown");
   property p_problem;
      meas_valid && pickup && !all_low |=> bus_state == BUS_LIVE_PROBLEM;
   endproperty
   a_problem: assert property (p_problem) else $error("problem not shown");
   property p_off;
      mode == MODE_OFF && meas_valid |=> !start ##1 !start || meas_valid;
   endproperty
   a_off: assert property (p_off) else $error("start while off");
   property p_force;
      stage_forcing_enable |=> condition == $past(ctrl[CTRL_FORCE_LSB +: 3]);
   endproperty
   a_force: assert property (p_force) else $error("forced status wrong");
   c_start: cover property (meas_valid && pickup && !block_in ##1 start);
   c_blocked: cover property (start ##[1:20] blocked);
   c_alarm: cover property ($rose(alarm));
   c_rev: cover property (bus_state == BUS_LIVE_REV);
endmodule : vts_core

// [design/vts_phase_cmp.sv]
// Limit comparison of one voltage channel
`timescale 1ns/1ns
module vts_phase_cmp
   import vts_pkg::*;
(
   // Measurement and limits
   input wire logic [MAG_W-1:0] mag,
   input wire logic [LIM_W-1:0] low_lim,
   input wire logic [LIM_W-1:0] high_lim,
   // Results
   output logic below_low,
   output logic above_high
);
   // Set limits against measured magnitude
   assign below_low = mag < {{(MAG_W-LIM_W){1'b0}}, low_lim};
   assign above_high = mag > {{(MAG_W-LIM_W){1'b0}}, high_lim};
endmodule : vts_phase_cmp

// [design/vts_pkg.sv]
// Constants, register map and enumerations of the voltage transformer supervision block
package vts_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_GRP0 = 8'h04;
   localparam logic [7:0] ADDR_GRP1 = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_SEQ = 8'h10;
   localparam logic [7:0] ADDR_ZERO = 8'h14;
   localparam logic [7:0] ADDR_DELAY = 8'h18;
   // Control field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_FORCE_LSB = 4;
   localparam int CTRL_BUSCHK_BIT = 8;
   localparam int CTRL_LINECHK_BIT = 9;
   localparam logic [31:0] CTRL_RST = 32'h0000_0300;
   // Group fields: low [7:0], high [15:8], angle limit [25:16]
   localparam int GRP_HIGH_LSB = 8;
   localparam int GRP_ANG_LSB = 16;
   // Magnitudes in 0.01 x nominal_voltage, angles in 0.1 degree
   localparam int MAG_W = 16;
   localparam int ANG_W = 12;
   localparam int LIM_W = 8;
   localparam int ALIM_W = 10;
   localparam logic [LIM_W-1:0] LOW_MIN = 8'h05;
   localparam logic [LIM_W-1:0] LOW_MAX = 8'h32;
   localparam logic [LIM_W-1:0] LOW_DEF = 8'h05;
   localparam logic [LIM_W-1:0] HIGH_MIN = 8'h01;
   localparam logic [LIM_W-1:0] HIGH_MAX = 8'h6E;
   localparam logic [LIM_W-1:0] HIGH_DEF = 8'h50;
   localparam logic [ALIM_W-1:0] ALIM_MIN = 10'h014;
   localparam logic [ALIM_W-1:0] ALIM_MAX = 10'h384;
   localparam logic [ALIM_W-1:0] ALIM_DEF = 10'h032;
   localparam logic [ANG_W-1:0] ANG_FULL = 12'hE10;
   localparam logic [ANG_W-1:0] ANG_HALF = 12'h708;
   localparam logic [ANG_W-1:0] ANG_THIRD = 12'h4B0;
   localparam logic [ANG_W-1:0] ANG_TWO_THIRD = 12'h960;
   localparam logic [ANG_W-1:0] SEQ_TOL = 12'h096;
   // Time base
   localparam int TIME_BASE_MS = 5;
   localparam int ANGLE_WINDOW_MS = 40;
   localparam int HIST_DEPTH = ANGLE_WINDOW_MS / TIME_BASE_MS;
   localparam logic [15:0] DELAY_DEF = 16'h0014;
   typedef enum logic [2:0] {
      MODE_ON = 3'b000, MODE_BLOCKED = 3'b001, MODE_TEST = 3'b010,
      MODE_TEST_BLOCKED = 3'b011, MODE_OFF = 3'b100
   } vts_mode_e;
   typedef enum logic [2:0] {
      COND_NORMAL = 3'b000, COND_START = 3'b001, COND_LINE_FAIL = 3'b010,
      COND_BUS_FAIL = 3'b011, COND_BLOCKED = 3'b100
   } vts_cond_e;
   typedef enum logic [2:0] {
      BUS_DEAD = 3'b000, BUS_LIVE_OK = 3'b001, BUS_LIVE_REV = 3'b010,
      BUS_LIVE_UNDEF = 3'b011, BUS_LIVE_PROBLEM = 3'b100
   } vts_bus_e;
endpackage : vts_pkg

// [tb/tb_top.sv]
// Self-checking testbench of the supervision core
`timescale 1ns/1ns
module tb_top;
   import vts_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, meas_valid, block_in;
   logic [MAG_W-1:0] mag0, mag1, mag2, mag3;
   logic [ANG_W-1:0] ang0, ang1, ang2, ang3;
   logic setting_group = 1'b0;
   logic individual_mode_allow = 1'b1;
   logic stage_forcing_enable = 1'b0;
   logic bus_miniature_breaker_trip = 1'b0;
   logic line_miniature_breaker_trip = 1'b0;
   logic start, blocked, alarm, bus_transformer_failure, line_transformer_failure;
   logic [2:0] condition, bus_state;
   int err_total = 0;
   int tests_run = 0;
   always #4 pclk = ~pclk;
   vts_core vts_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .meas_valid(meas_valid), .mag0(mag0), .mag1(mag1), .mag2(mag2),
      .mag3(mag3), .ang0(ang0), .ang1(ang1), .ang2(ang2), .ang3(ang3), .block_in(block_in),
      .setting_group(setting_group), .individual_mode_allow(individual_mode_allow),
      .stage_forcing_enable(stage_forcing_enable),
      .bus_miniature_breaker_trip(bus_miniature_breaker_trip),
      .line_miniature_breaker_trip(line_miniature_breaker_trip), .start(start),
      .blocked(blocked), .alarm(alarm), .bus_transformer_failure(bus_transformer_failure),
      .line_transformer_failure(line_transformer_failure), .condition(condition),
      .bus_state(bus_state));
   vts_meas_src vts_meas_src_inst (.pclk(pclk), .meas_valid(meas_valid), .mag0(mag0),
      .mag1(mag1), .mag2(mag2), .mag3(mag3), .ang0(ang0), .ang1(ang1), .ang2(ang2),
      .ang3(ang3), .block_in(block_in));
   task automatic chk(input logic [31:0] g, e);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic chkb(input logic g, e);
      chk({31'h0, g}, {31'h0, e});
   endtask : chkb
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc
   task automatic meas(input logic [MAG_W-1:0] m0, m1, m2, input int sep, stp, input logic b);
      vts_meas_src_inst.send(m0, m1, m2, sep, stp, b);
   endtask : meas
   task automatic fault(input int n, stp, input logic b);
      repeat (n) meas(16'h0000, 16'h0064, 16'h0064, 1200, stp, b);
   endtask : fault
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize
   initial begin
      #200000;
      err_total++;
      summarize();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      chk({29'h0, bus_state}, {29'h0, BUS_DEAD});
      rdc(ADDR_CTRL, CTRL_RST);
      rdc(ADDR_GRP0, 32'h0032_5005);
      rdc(ADDR_DELAY, 32'h0000_0014);
      apb(1'b1, ADDR_GRP1, 32'h0000_00FF);
      rdc(ADDR_GRP1, 32'h0014_0132);
      apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
      rdc(8'h1C, 32'h0);
      chkb(er, 1'b1);
      done("registers");
      meas(16'h0000, 16'h0000, 16'h0000, 1200, 30, 1'b0);
      chk({29'h0, bus_state}, {29'h0, BUS_DEAD});
      meas(16'h0064, 16'h0064, 16'h0064, 1200, 30, 1'b0);
      chk({29'h0, bus_state}, {29'h0, BUS_LIVE_OK});
      rdc(ADDR_SEQ, 32'h0000_0064);
      meas(16'h0064, 16'h0064, 16'h0064, 2400, 30, 1'b0);
      chk({29'h0, bus_state}, {29'h0, BUS_LIVE_REV});
      meas(16'h0064, 16'h0064, 16'h0064, 0, 30, 1'b0);
      chk({29'h0, bus_state}, {29'h0, BUS_LIVE_UNDEF});
      done("sequence");
      meas(16'h0000, 16'h0064, 16'h0032, 1200, 30, 1'b0);
      chkb(start, 1'b0);
      fault(1, 30, 1'b0);
      chkb(start, 1'b1);
      chk({29'h0, bus_state}, {29'h0, BUS_LIVE_PROBLEM});
      chk({29'h0, condition}, {29'h0, COND_START});
      rdc(ADDR_STATUS, 32'h0009_6141);
      rdc(ADDR_ZERO, 32'h0000_0064);
      done("pickup");
      apb(1'b1, ADDR_DELAY, 32'h0000_0003);
      meas(16'h0064, 16'h0064, 16'h0064, 1200, 30, 1'b0);
      fault(1, 30, 1'b0);
      chkb(alarm, 1'b0);
      fault(1, 30, 1'b0);
      chkb(alarm, 1'b0);
      fault(1, 30, 1'b0);
      chkb(alarm, 1'b1);
      chkb(bus_transformer_failure, 1'b1);
      fault(1, 30, 1'b1);
      chkb(start, 1'b0);
      chkb(blocked, 1'b1);
      chk({29'h0, condition}, {29'h0, COND_BLOCKED});
      done("alarm and blocking");
      fault(9, 6, 1'b0);
      chkb(start, 1'b0);
      fault(9, 7, 1'b0);
      chkb(start, 1'b1);
      done("angle shift");
      setting_group <= 1'b1;
      meas(16'h0028, 16'h0064, 16'h0064, 1200, 30, 1'b0);
      chkb(start, 1'b1);
      setting_group <= 1'b0;
      meas(16'h0028, 16'h0064, 16'h0064, 1200, 30, 1'b0);
      chkb(start, 1'b0);
      done("setting groups");
      for (int m = 0; m < 5; m++) begin
         apb(1'b1, ADDR_CTRL, 32'h0000_0300 | m);
         fault(1, 30, 1'b0);
         chkb(start, m == 0 || m == 2);
         chkb(blocked, m == 1 || m == 3);
      end
      setting_group <= 1'b1;
      rdc(ADDR_CTRL, 32'h0000_0304);
      individual_mode_allow <= 1'b0;
      fault(1, 30, 1'b0);
      chkb(start, 1'b1);
      individual_mode_allow <= 1'b1;
      setting_group <= 1'b0;
      stage_forcing_enable <= 1'b1;
      for (int f = 0; f < 5; f++) begin
         apb(1'b1, ADDR_CTRL, 32'h0000_0300 | (f << 4));
         repeat (3) @(posedge pclk);
         #1;
         chk({29'h0, condition}, f);
      end
      setting_group <= 1'b1;
      repeat (3) @(posedge pclk);
      #1;
      chk({29'h0, condition}, {29'h0, COND_BLOCKED});
      stage_forcing_enable <= 1'b0;
      setting_group <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h0000_0300);
      done("modes and forcing");
      bus_miniature_breaker_trip <= 1'b1;
      line_miniature_breaker_trip <= 1'b1;
      meas(16'h0064, 16'h0064, 16'h0064, 1200, 30, 1'b0);
      chkb(bus_transformer_failure, 1'b1);
      chkb(line_transformer_failure, 1'b1);
      apb(1'b1, ADDR_CTRL, 32'h0000_0000);
      meas(16'h0064, 16'h0064, 16'h0064, 1200, 30, 1'b0);
      chkb(bus_transformer_failure, 1'b0);
      chkb(line_transformer_failure, 1'b0);
      done("fuse checks");
      summarize();
   end
endmodule : tb_top

// [tb/vts_meas_src.sv]
// Measurement channel and blocking source model
`timescale 1ns/1ns
module vts_meas_src
   import vts_pkg::*;
(
   // Clock
   input wire logic pclk,
   // Measurement set
   output logic meas_valid,
   output logic [MAG_W-1:0] mag0,
   output logic [MAG_W-1:0] mag1,
   output logic [MAG_W-1:0] mag2,
   output logic [MAG_W-1:0] mag3,
   output logic [ANG_W-1:0] ang0,
   output logic [ANG_W-1:0] ang1,
   output logic [ANG_W-1:0] ang2,
   output logic [ANG_W-1:0] ang3,
   // Blocking matrix
   output logic block_in
);
   int rot = 0;
   initial begin
      meas_valid = 1'b0;
      {mag0, mag1, mag2, mag3} = '0;
      {ang0, ang1, ang2, ang3} = '0;
      block_in = 1'b0;
   end
   // One update: phasors rotate by stp, phases spaced by sep
   task automatic send(input logic [MAG_W-1:0] m0, m1, m2, input int sep, stp, input logic blk);
      @(posedge pclk);
      rot = (rot + stp) % 3600;
      meas_valid <= 1'b1;
      mag0 <= m0;
      mag1 <= m1;
      mag2 <= m2;
      mag3 <= m0;
      ang0 <= ANG_W'(rot);
      ang1 <= ANG_W'((rot + 3600 - sep) % 3600);
      ang2 <= ANG_W'((rot + 7200 - 2 * sep) % 3600);
      ang3 <= ANG_W'(rot);
      block_in <= blk;
      @(posedge pclk);
      meas_valid <= 1'b0;
      repeat (2) @(posedge pclk);
      #1;
   endtask : send
endmodule : vts_meas_src
